// >>> xclu_regs.vh
/*
 Constants for the exclusive-OR and complement logic unit: function codes,
 operand widths and the word reset value.
 Assumes the instruction sequencer presents one decoded function code per execution step.
*/
// How it works
// - Function code 036 writes the bitwise XOR of two 16-bit input words to the result word.
// - Function code 612 XORs two 32-bit operands bit by bit into a 32-bit result.
// - For double words, word n is the low half and word n+1 the high half, for inputs and result.
// - Function code 029 inverts every bit of the target word and writes it back in place.
// - Function code 614 inverts all 32 bits of the target word pair and writes both back in place.
// - In the plain form complement acts on every enabled cycle, so a held condition toggles the word each cycle.
// - After each operation the equals flag is set when the result is zero and cleared otherwise.
// - After each operation the negative flag follows the result's top bit and the error flag is cleared.
// - Nothing executes while the execution condition is false, and the result words stay unchanged.
`ifndef XCLU_REGS_VH
`define XCLU_REGS_VH
`define XCLU_FUNC_W 12
`define XCLU_FN_XOR_SINGLE 12'h036
`define XCLU_FN_XOR_DOUBLE 12'h612
`define XCLU_FN_INV_SINGLE 12'h029
`define XCLU_FN_INV_DOUBLE 12'h614
`define XCLU_WORD_W 16
`define XCLU_DWORD_W 32
`define XCLU_WORD_RST 16'h0000
`endif

// >>> xclu_unit.v
/*
 Exclusive-OR and complement logic unit: single and double word XOR into a result
 pair, in-place single and double word complement, and the error, equals and negative flags.
 Assumes the instruction sequencer drives all inputs synchronously on SYS_CLK, so no
 synchroniser is used. The function code is a BCD-style hex value (036, 612, 029, 614).
*/
`include "xclu_regs.vh"
module xclu_unit (
   input wire SYS_CLK,
   input wire RST,
   input wire EXEC_COND,
   input wire DIFF_MODE,
   input wire [`XCLU_FUNC_W-1:0] FUNC_CODE,
   input wire [`XCLU_WORD_W-1:0] IN1_LO,
   input wire [`XCLU_WORD_W-1:0] IN1_HI,
   input wire [`XCLU_WORD_W-1:0] IN2_LO,
   input wire [`XCLU_WORD_W-1:0] IN2_HI,
   input wire TARGET_LOAD,
   input wire [`XCLU_WORD_W-1:0] TARGET_WORD_LO_IN,
   input wire [`XCLU_WORD_W-1:0] TARGET_WORD_HI_IN,
   output reg [`XCLU_WORD_W-1:0] RESULT_LO,
   output reg [`XCLU_WORD_W-1:0] RESULT_HI,
   output reg [`XCLU_WORD_W-1:0] TARGET_WORD_LO,
   output reg [`XCLU_WORD_W-1:0] TARGET_WORD_HI,
   output reg ERROR_FLAG,
   output reg EQUALS_FLAG,
   output reg NEGATIVE_FLAG,
   output reg DONE
);

   // Decoded operation kinds; every code outside the four is a no-operation
   localparam [2:0] OP_NONE = 3'h0;
   localparam [2:0] OP_XOR_SINGLE = 3'h1;
   localparam [2:0] OP_XOR_DOUBLE = 3'h2;
   localparam [2:0] OP_INV_SINGLE = 3'h3;
   localparam [2:0] OP_INV_DOUBLE = 3'h4;

   // Condition as seen on the previous edge, for the differentiated form
   reg cond_prev_reg;
   reg cond_prev_next;

   // Next values of the registered outputs
   reg [`XCLU_WORD_W-1:0] result_lo_next;
   reg [`XCLU_WORD_W-1:0] result_hi_next;
   reg [`XCLU_WORD_W-1:0] target_lo_next;
   reg [`XCLU_WORD_W-1:0] target_hi_next;
   reg error_next;
   reg equals_next;
   reg negative_next;
   reg done_next;

   // Operand pairs, per-bit logic and write enables
   reg [`XCLU_DWORD_W-1:0] res;
   wire [`XCLU_DWORD_W-1:0] in1;
   wire [`XCLU_DWORD_W-1:0] in2;
   wire [`XCLU_DWORD_W-1:0] tgt;
   wire [`XCLU_DWORD_W-1:0] xor_bits;
   wire [`XCLU_DWORD_W-1:0] inv_bits;
   wire [2:0] op;
   wire fire;
   wire exec;
   wire dbl;
   wire inv_op;
   wire res_lo_we;
   wire res_hi_we;
   wire tgt_lo_we;
   wire tgt_hi_we;
   wire [1:0] flags_now;

   // One decoder for the operand path and the write-back path keeps both in step
   function [2:0] decode_op;
      input [`XCLU_FUNC_W-1:0] code;
      begin
         case (code)
            `XCLU_FN_XOR_SINGLE: decode_op = OP_XOR_SINGLE;
            `XCLU_FN_XOR_DOUBLE: decode_op = OP_XOR_DOUBLE;
            `XCLU_FN_INV_SINGLE: decode_op = OP_INV_SINGLE;
            `XCLU_FN_INV_DOUBLE: decode_op = OP_INV_DOUBLE;
            default: decode_op = OP_NONE;
         endcase
      end
   endfunction

   function is_double;
      input [2:0] kind;
      begin
         is_double = (kind == OP_XOR_DOUBLE) || (kind == OP_INV_DOUBLE);
      end
   endfunction

   function is_invert;
      input [2:0] kind;
      begin
         is_invert = (kind == OP_INV_SINGLE) || (kind == OP_INV_DOUBLE);
      end
   endfunction

   // Flags follow the width of the operation: top bit of a word, or of a pair
   function [1:0] result_flags;
      input [`XCLU_DWORD_W-1:0] value;
      input wide;
      begin
         if (wide) begin
            result_flags = {~|value, value[`XCLU_DWORD_W-1]};
         end else begin
            result_flags = {~|value[`XCLU_WORD_W-1:0], value[`XCLU_WORD_W-1]};
         end
      end
   endfunction

   // Word n is the low half and word n+1 the high half of every pair
   assign in1 = {IN1_HI, IN1_LO};
   assign in2 = {IN2_HI, IN2_LO};
   assign tgt = {TARGET_WORD_HI, TARGET_WORD_LO};

   // Bit slices are independent, so each is one gate
   genvar bit_idx;
   generate
      for (bit_idx = 0; bit_idx < `XCLU_DWORD_W; bit_idx = bit_idx + 1) begin : g_bit
         assign xor_bits[bit_idx] = in1[bit_idx] ^ in2[bit_idx];
         assign inv_bits[bit_idx] = ~tgt[bit_idx];
      end
   endgenerate

   // Differentiated form fires on the rising edge only; plain form every enabled cycle
   assign fire = DIFF_MODE ? (EXEC_COND & ~cond_prev_reg) : EXEC_COND;
   assign op = decode_op(FUNC_CODE);
   assign exec = fire & (op != OP_NONE);
   assign dbl = is_double(op);
   assign flags_now = result_flags(res, dbl);

   // Which halves an executing operation writes back
   assign inv_op = is_invert(op);
   assign res_lo_we = exec & ~inv_op;
   assign res_hi_we = exec & ~inv_op & dbl;
   assign tgt_lo_we = exec & inv_op;
   assign tgt_hi_we = exec & inv_op & dbl;

   // Result of the decoded operation; zero when nothing is decoded
   always @* begin
      res = {`XCLU_DWORD_W{1'h0}};
      case (op)
         OP_XOR_SINGLE: begin
            res = {{`XCLU_WORD_W{1'h0}}, xor_bits[`XCLU_WORD_W-1:0]};
         end
         OP_XOR_DOUBLE: begin
            res = xor_bits;
         end
         OP_INV_SINGLE: begin
            res = {{`XCLU_WORD_W{1'h0}}, inv_bits[`XCLU_WORD_W-1:0]};
         end
         OP_INV_DOUBLE: begin
            res = inv_bits;
         end
         default: begin
            res = {`XCLU_DWORD_W{1'h0}};
         end
      endcase
   end

   // Next-value logic: every output but DONE holds unless an executed operation or a load writes it
   always @* begin
      cond_prev_next = EXEC_COND;
      result_lo_next = RESULT_LO;
      result_hi_next = RESULT_HI;
      target_lo_next = TARGET_WORD_LO;
      target_hi_next = TARGET_WORD_HI;
      error_next = ERROR_FLAG;
      equals_next = EQUALS_FLAG;
      negative_next = NEGATIVE_FLAG;
      done_next = exec;
      // A load and an executing complement on one edge: the complement wins on the words it
      // writes, and it works on the word held before the load
      if (TARGET_LOAD) begin
         target_lo_next = TARGET_WORD_LO_IN;
         target_hi_next = TARGET_WORD_HI_IN;
      end
      if (exec) begin
         error_next = 1'h0;
         equals_next = flags_now[1];
         negative_next = flags_now[0];
      end
      if (res_lo_we) begin
         result_lo_next = res[`XCLU_WORD_W-1:0];
      end
      if (res_hi_we) begin
         result_hi_next = res[`XCLU_DWORD_W-1:`XCLU_WORD_W];
      end
      // In the plain form runs on every enabled cycle, so a held condition toggles the word
      if (tgt_lo_we) begin
         target_lo_next = res[`XCLU_WORD_W-1:0];
      end
      if (tgt_hi_we) begin
         target_hi_next = res[`XCLU_DWORD_W-1:`XCLU_WORD_W];
      end
   end

   // Every output is a flip-flop; all choices are made in the next-value logic
   always @(posedge SYS_CLK) begin
      if (RST) begin
         cond_prev_reg <= 1'h0;
         RESULT_LO <= `XCLU_WORD_RST;
         RESULT_HI <= `XCLU_WORD_RST;
         TARGET_WORD_LO <= `XCLU_WORD_RST;
         TARGET_WORD_HI <= `XCLU_WORD_RST;
         ERROR_FLAG <= 1'h0;
         EQUALS_FLAG <= 1'h0;
         NEGATIVE_FLAG <= 1'h0;
         DONE <= 1'h0;
      end else begin
         cond_prev_reg <= cond_prev_next;
         RESULT_LO <= result_lo_next;
         RESULT_HI <= result_hi_next;
         TARGET_WORD_LO <= target_lo_next;
         TARGET_WORD_HI <= target_hi_next;
         ERROR_FLAG <= error_next;
         EQUALS_FLAG <= equals_next;
         NEGATIVE_FLAG <= negative_next;
         DONE <= done_next;
      end
   end

endmodule // xclu_unit

// >>> xclu_seq.sv
/* Sequencer model: condition, mode and code.
 Assumes one step call per cycle. */
module xclu_seq(
   input wire logic clk,
   output logic cond,
   output logic dm,
   output logic [11:0] fc
);
   timeunit 1ns; timeprecision 1ps;
   initial {cond, dm, fc} = '0;
   // Falling edge, so the unit samples settled values
   task step(input logic c, d, input logic [11:0] f);
      @(negedge clk);
      {cond, dm, fc} = {c, d, f};
   endtask
endmodule // xclu_seq

// >>> xclu_unit_assertions.sv
/* Port checker for the logic unit.
 Assumes one clock and binding onto xclu_unit. */
module xclu_chk(
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic EXEC_COND,
   input wire logic DIFF_MODE,
   input wire logic DONE,
   input wire logic ERROR_FLAG,
   input wire logic EQUALS_FLAG,
   input wire logic NEGATIVE_FLAG,
   input wire logic [11:0] FUNC_CODE,
   input wire logic [15:0] IN1_LO,
   input wire logic [15:0] IN1_HI,
   input wire logic [15:0] IN2_LO,
   input wire logic [15:0] IN2_HI,
   input wire logic [15:0] RESULT_LO,
   input wire logic [15:0] RESULT_HI,
   input wire logic [15:0] TARGET_WORD_LO,
   input wire logic [15:0] TARGET_WORD_HI
);
   timeunit 1ns; timeprecision 1ps;
   logic cp;
   always @(posedge SYS_CLK) cp <= RST ? 1'h0 : EXEC_COND;
   wire f = EXEC_COND & (!DIFF_MODE | !cp);
   wire k = FUNC_CODE inside {12'h036, 12'h612, 12'h029, 12'h614};
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   xor_word_a: assert property (f && FUNC_CODE == 12'h036 |=> RESULT_LO == $past(IN1_LO ^ IN2_LO))
      else $error("xor word");
   xor_dword_a: assert property (f && FUNC_CODE == 12'h612 |=>
      {RESULT_HI, RESULT_LO} == $past({IN1_HI, IN1_LO} ^ {IN2_HI, IN2_LO})) else $error("xor dword");
   inv_word_a: assert property (f && FUNC_CODE == 12'h029 |=> TARGET_WORD_LO == ~$past(TARGET_WORD_LO))
      else $error("inv word");
   inv_dword_a: assert property (f && FUNC_CODE == 12'h614 |=>
      {TARGET_WORD_HI, TARGET_WORD_LO} == ~$past({TARGET_WORD_HI, TARGET_WORD_LO})) else $error("inv dword");
   dword_flags_a: assert property (f && FUNC_CODE == 12'h614 |=> !ERROR_FLAG &&
      EQUALS_FLAG == ({TARGET_WORD_HI, TARGET_WORD_LO} == 32'h0) && NEGATIVE_FLAG == TARGET_WORD_HI[15])
      else $error("dword flags");
   word_flags_a: assert property (f && FUNC_CODE == 12'h036 |=> !ERROR_FLAG &&
      EQUALS_FLAG == (RESULT_LO == 0) && NEGATIVE_FLAG == RESULT_LO[15]) else $error("flags");
   held_fire_a: assert property (f && k |=> DONE) else $error("no done");
   cond_off_a: assert property (!f |=> !DONE && $stable({RESULT_HI, RESULT_LO})) else $error("idle");
   edge_only_a: assert property (DIFF_MODE && cp |=> !DONE) else $error("diff");
   cover property (f && FUNC_CODE == 12'h614 ##1 f && FUNC_CODE == 12'h614);
   cover property (DIFF_MODE && cp && EXEC_COND);
   cover property (DONE && EQUALS_FLAG);
endmodule // xclu_chk
bind xclu_unit xclu_chk xclu_chk_inst(.*);

// >>> xclu_unit_tb.sv
/* Random bench for the logic unit with a reference model.
 Assumes the sequencer model drives code and condition. */
`include "xclu_regs.vh"
module xclu_unit_tb;
   timeunit 1ns; timeprecision 1ps;
   logic SYS_CLK = 0, RST = 1, EXEC_COND, DIFF_MODE, TARGET_LOAD = 0, ERROR_FLAG, EQUALS_FLAG, NEGATIVE_FLAG;
   logic DONE, c, d, pc = 0;
   logic [11:0] FUNC_CODE, f;
   logic [15:0] IN1_LO = 0, IN1_HI = 0, IN2_LO = 0, IN2_HI = 0, TARGET_WORD_LO_IN = 0, TARGET_WORD_HI_IN = 0;
   logic [15:0] RESULT_LO, RESULT_HI, TARGET_WORD_LO, TARGET_WORD_HI;
   logic [31:0] res = 0, tg = 0, nt;
   logic [3:0] fl = 0;
   logic [11:0] codes [5] = '{`XCLU_FN_XOR_SINGLE, `XCLU_FN_XOR_DOUBLE, `XCLU_FN_INV_SINGLE,
      `XCLU_FN_INV_DOUBLE, 12'h035};
   int num_errors = 0, cmp_count = 0;
   always #2.5 SYS_CLK = ~SYS_CLK;
   xclu_seq xclu_seq_inst(.clk(SYS_CLK), .cond(EXEC_COND), .dm(DIFF_MODE), .fc(FUNC_CODE));
   xclu_unit xclu_unit_inst(.*);
   function automatic logic [3:0] flg(input logic [31:0] v, input logic dbl);
      return {1'h0, dbl ? v == 32'h0 : v[15:0] == 16'h0, dbl ? v[31] : v[15], 1'h1};
   endfunction
   task end_sim;
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      void'($urandom(81374));
      repeat (5) @(negedge SYS_CLK);
      RST = 0;
      // First eight steps: held double invert, then a held differentiated single invert
      for (int i = 0; i < 600; i++) begin
         c = i < 8 ? i != 4 : $urandom % 4 != 0;
         d = i < 8 ? i > 4 : $urandom % 2;
         f = i < 8 ? codes[2 + (i < 4)] : codes[$urandom % 5];
         xclu_seq_inst.step(c, d, f);
         {IN1_HI, IN1_LO, IN2_HI, IN2_LO} = {$urandom, $urandom};
         if (i % 9 == 0) {IN2_HI, IN2_LO} = {IN1_HI, IN1_LO};
         TARGET_LOAD = i > 7 && $urandom % 4 == 0;
         {TARGET_WORD_HI_IN, TARGET_WORD_LO_IN} = $urandom;
         nt = TARGET_LOAD ? {TARGET_WORD_HI_IN, TARGET_WORD_LO_IN} : tg;
         fl[0] = 0;
         if (c && (!d || !pc) && f != codes[4]) case (f)
            `XCLU_FN_XOR_SINGLE: begin res[15:0] = IN1_LO ^ IN2_LO; fl = flg(res, 0); end
            `XCLU_FN_XOR_DOUBLE: begin res = {IN1_HI, IN1_LO} ^ {IN2_HI, IN2_LO}; fl = flg(res, 1); end
            `XCLU_FN_INV_SINGLE: begin nt[15:0] = ~tg[15:0]; fl = flg(nt, 0); end
            default: begin nt = ~tg; fl = flg(nt, 1); end
         endcase
         {pc, tg} = {c, nt};
         @(posedge SYS_CLK) #1;
         cmp_count++;
         if ({RESULT_HI, RESULT_LO, TARGET_WORD_HI, TARGET_WORD_LO, ERROR_FLAG, EQUALS_FLAG, NEGATIVE_FLAG, DONE}
            !== {res, tg, fl}) begin
            num_errors++;
            $display("[ERR] outputs exp %h got %h", {res, tg, fl}, {RESULT_HI, RESULT_LO, TARGET_WORD_HI,
               TARGET_WORD_LO, ERROR_FLAG, EQUALS_FLAG, NEGATIVE_FLAG, DONE});
         end
         if (i == 7) $display("corner test done");
      end
      $display("random test done");
      end_sim;
   end
endmodule // xclu_unit_tb
